// >>> verilog/rsg_top.sv
// Rail sequence and group logic of one output rail, with an APB slave.
// Assumes synchronous event bus ports and a strap decode that is stable
// when reset is released.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module rsg_top
  import rsg_pkg::*;
#(
  parameter int OFF_DLY = OFF_DLY_DEF
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] cfg_strap,
  input wire logic en_pin,
  input wire logic power_good_signal,
  input wire logic vout_zero,
  input wire logic supply_loss,
  input wire logic evt_rx_valid,
  input rsg_evt_t evt_rx,
  output logic evt_tx_valid,
  output rsg_evt_t evt_tx,
  input wire logic evt_tx_ready,
  output logic out_en,
  output logic [15:0] vout_cmd
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_OFF, ST_WAIT_PRE, ST_ON, ST_WAIT_SEQ, ST_DELAY
  } rsg_state_t;

  rsg_state_t state_r, state_nxt;
  logic [15:0] seq_r, seq_nxt;
  logic seq_wr_r, seq_wr_nxt;
  logic [31:0] grp_r, grp_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic loaded_r, loaded_nxt;
  logic op_on_r, op_on_nxt;
  logic pre_seen_r, pre_seen_nxt;
  logic [15:0] dly_r, dly_nxt;
  logic out_en_r, out_en_nxt;
  logic [15:0] vout_r, vout_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [4:0] pend_r, pend_nxt;
  logic tx_v_r, tx_v_nxt;
  rsg_evt_t tx_r, tx_nxt;
  logic pg_d_r, pg_d_nxt;
  logic zero_d_r, zero_d_nxt;
  logic pf_d_r, pf_d_nxt;
  rsg_seq_t seq_eff;
  rsg_hit_t hit;
  logic wr_acc, setup, mapped, want_on;
  logic [4:0] pend_set;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Strap sequencing: prequel only, sequel is never strapped.
  function automatic logic [15:0] strap_seq(input logic [7:0] s);
    strap_seq = 16'h0000;
    strap_seq[SEQ_PRE_EN] = s[7];
    strap_seq[SEQ_PRE_LSB +: ID_W] = s[4:0];
  endfunction

  // One strapped ID serves all three groups; enables from the top bits.
  function automatic logic [31:0] strap_grp(input logic [7:0] s);
    strap_grp = 32'h00000000;
    strap_grp[GRP_VOUT_LSB +: ID_W] = s[4:0];
    strap_grp[GRP_OP_LSB +: ID_W] = s[4:0];
    strap_grp[GRP_PF_LSB +: ID_W] = s[4:0];
    strap_grp[GRP_VOUT_EN] = s[5];
    strap_grp[GRP_OP_EN] = s[6];
    strap_grp[GRP_PF_IMM] = s[7];
  endfunction

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = a == ADR_SEQ || a == ADR_GRP || a == ADR_CTRL ||
      a == ADR_SEND || a == ADR_STAT;
  endfunction

  // ------------------------------------------------------------------
  // Event decode
  // ------------------------------------------------------------------
  // Until software writes the sequencing register, the strap rules.
  assign seq_eff = seq_of(seq_wr_r ? seq_r : strap_seq(cfg_strap));

  rsg_event_rx u_rx
  (
    .evt_valid(evt_rx_valid),
    .evt(evt_rx),
    .seq(seq_eff),
    .grp(grp_r),
    .two_phase(ctrl_r[CTRL_2PH]),
    .hit(hit)
  );

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  // One wait-free access phase: pready rises on the first access cycle.
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready_r && pwrite && !pslverr_r;
  assign mapped = addr_hit(paddr);

  always_comb
  begin
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    seq_nxt = seq_r;
    seq_wr_nxt = seq_wr_r;
    grp_nxt = grp_r;
    ctrl_nxt = ctrl_r;
    loaded_nxt = 1'b1;
    if (!loaded_r)
    begin
      grp_nxt = strap_grp(cfg_strap);
    end
    if (setup)
    begin
      pready_nxt = 1'b1;
      pslverr_nxt = !mapped;
      prdata_nxt = 32'h00000000;
      if (!pwrite)
      begin
        unique case (paddr)
          ADR_SEQ: prdata_nxt = {16'h0000, seq_r};
          ADR_GRP: prdata_nxt = grp_r;
          // Bit 0 reads the live operation state, which broadcasts move.
          ADR_CTRL: prdata_nxt = {ctrl_r[31:1], op_on_r};
          ADR_STAT: prdata_nxt = {26'h0, pend_r != 5'h00, pre_seen_r,
            state_r, out_en_r};
          default: prdata_nxt = 32'h00000000;
        endcase
      end
    end
    if (wr_acc)
    begin
      unique case (paddr)
        ADR_SEQ:
        begin
          seq_nxt = pwdata[15:0] & SEQ_MASK;
          seq_wr_nxt = 1'b1;
        end
        ADR_GRP: grp_nxt = pwdata & GRP_MASK;
        ADR_CTRL: ctrl_nxt = pwdata & CTRL_MASK;
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      seq_r <= SEQ_RST;
      seq_wr_r <= 1'b0;
      grp_r <= 32'h00000000;
      ctrl_r <= CTRL_RST;
      loaded_r <= 1'b0;
    end
    else if (ce)
    begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      seq_r <= seq_nxt;
      seq_wr_r <= seq_wr_nxt;
      grp_r <= grp_nxt;
      ctrl_r <= ctrl_nxt;
      loaded_r <= loaded_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Sequencing state machine
  // ------------------------------------------------------------------
  // The operation state follows software or a matched broadcast.
  assign want_on = en_pin && op_on_r;

  always_comb
  begin
    state_nxt = state_r;
    out_en_nxt = out_en_r;
    dly_nxt = dly_r;
    op_on_nxt = op_on_r;
    vout_nxt = vout_r;
    pre_seen_nxt = pre_seen_r;
    if (wr_acc && paddr == ADR_CTRL)
    begin
      op_on_nxt = pwdata[CTRL_ON];
    end
    if (hit.op)
    begin
      op_on_nxt = evt_rx.data[OP_ON_BIT];
    end
    if (hit.vout)
    begin
      vout_nxt = evt_rx.data;
    end
    if (hit.pre_pg)
    begin
      pre_seen_nxt = 1'b1;
    end
    unique case (state_r)
      ST_OFF:
      begin
        if (want_on)
        begin
          state_nxt = ST_WAIT_PRE;
        end
      end
      ST_WAIT_PRE:
      begin
        if (!want_on)
        begin
          state_nxt = ST_OFF;
        end
        else if (!seq_eff.pre_en || pre_seen_r || hit.pre_pg)
        begin
          state_nxt = ST_ON;
          out_en_nxt = 1'b1;
        end
      end
      ST_ON:
      begin
        if (!want_on || hit.pf_seq)
        begin
          state_nxt = seq_eff.seq_en ? ST_WAIT_SEQ : ST_DELAY;
          dly_nxt = 16'(OFF_DLY);
        end
      end
      ST_WAIT_SEQ:
      begin
        if (hit.seq_pd)
        begin
          state_nxt = ST_DELAY;
          dly_nxt = 16'(OFF_DLY);
        end
      end
      ST_DELAY:
      begin
        if (dly_r == 16'h0000)
        begin
          state_nxt = ST_OFF;
          out_en_nxt = 1'b0;
        end
        else
        begin
          dly_nxt = dly_r - 16'h0001;
        end
      end
    endcase
    // A matched immediate loss beats any sequencing in progress.
    if (hit.pf_imm)
    begin
      state_nxt = ST_OFF;
      out_en_nxt = 1'b0;
      op_on_nxt = 1'b0;
    end
    if (state_nxt == ST_OFF)
    begin
      pre_seen_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_OFF;
      out_en_r <= 1'b0;
      dly_r <= 16'h0000;
      op_on_r <= 1'b0;
      vout_r <= 16'h0000;
      pre_seen_r <= 1'b0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      out_en_r <= out_en_nxt;
      dly_r <= dly_nxt;
      op_on_r <= op_on_nxt;
      vout_r <= vout_nxt;
      pre_seen_r <= pre_seen_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Event transmit
  // ------------------------------------------------------------------
  // Pending bits: 0 power good, 1 power down, 2 voltage, 3 operation,
  // 4 supply loss. Only one message is in flight, so requests queue as
  // flags; a request in the cycle its flag clears is kept.
  always_comb
  begin
    pend_set = 5'h00;
    pend_set[0] = power_good_signal && !pg_d_r && out_en_r;
    pend_set[1] = vout_zero && !zero_d_r && !out_en_r;
    pend_set[4] = supply_loss && !pf_d_r;
    if (wr_acc && paddr == ADR_SEND)
    begin
      pend_set[2] = pwdata[0];
      pend_set[3] = pwdata[1];
      pend_set[4] = pend_set[4] | pwdata[2];
    end
  end

  always_comb
  begin
    pend_nxt = pend_r;
    tx_v_nxt = tx_v_r;
    tx_nxt = tx_r;
    pg_d_nxt = power_good_signal;
    zero_d_nxt = vout_zero;
    pf_d_nxt = supply_loss;
    if (tx_v_r && evt_tx_ready)
    begin
      tx_v_nxt = 1'b0;
    end
    if (!tx_v_nxt)
    begin
      tx_nxt = '0;
      tx_nxt.id = ctrl_r[CTRL_ID_LSB +: ID_W];
      if (pend_r[4])
      begin
        tx_nxt.kind = EV_PFAIL;
        tx_nxt.data = {11'h000, grp_r[GRP_PF_LSB +: ID_W]};
        pend_nxt[4] = 1'b0;
      end
      else if (pend_r[0])
      begin
        tx_nxt.kind = EV_PG;
        pend_nxt[0] = 1'b0;
      end
      else if (pend_r[1])
      begin
        tx_nxt.kind = EV_PDOWN;
        pend_nxt[1] = 1'b0;
      end
      else if (pend_r[2])
      begin
        tx_nxt.kind = EV_VOUT;
        tx_nxt.data = {11'h000, grp_r[GRP_VOUT_LSB +: ID_W]};
        pend_nxt[2] = 1'b0;
      end
      else if (pend_r[3])
      begin
        tx_nxt.kind = EV_OP;
        tx_nxt.data = {11'h000, grp_r[GRP_OP_LSB +: ID_W]};
        pend_nxt[3] = 1'b0;
      end
      tx_v_nxt = pend_r != 5'h00;
    end
    pend_nxt = pend_nxt | pend_set;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pend_r <= 5'h00;
      tx_v_r <= 1'b0;
      tx_r <= '0;
      pg_d_r <= 1'b0;
      zero_d_r <= 1'b0;
      pf_d_r <= 1'b0;
    end
    else if (ce)
    begin
      pend_r <= pend_nxt;
      tx_v_r <= tx_v_nxt;
      tx_r <= tx_nxt;
      pg_d_r <= pg_d_nxt;
      zero_d_r <= zero_d_nxt;
      pf_d_r <= pf_d_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign evt_tx_valid = tx_v_r;
  assign evt_tx = tx_r;
  assign out_en = out_en_r;
  assign vout_cmd = vout_r;

endmodule // rsg_top

// >>> verilog/rsg_pkg.sv
// Shared constants and carriers of the rail sequence and group logic.
// Assumes one 20 MHz clock and a synchronous, active-low reset.
package rsg_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] SEQ_IDX = 12'h0e0;
  localparam logic [11:0] GRP_IDX = 12'h0e2;
  localparam logic [11:0] ADR_SEQ = {SEQ_IDX[9:0], 2'b00};
  localparam logic [11:0] ADR_GRP = {GRP_IDX[9:0], 2'b00};
  localparam logic [11:0] ADR_CTRL = 12'h000;
  localparam logic [11:0] ADR_SEND = 12'h004;
  localparam logic [11:0] ADR_STAT = 12'h008;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int ID_W = 5;
  localparam int SEQ_PRE_EN = 15;
  localparam int SEQ_PRE_LSB = 8;
  localparam int SEQ_SEQ_EN = 7;
  localparam int SEQ_SEQ_LSB = 0;
  localparam logic [15:0] SEQ_MASK = 16'h9f9f;
  localparam logic [15:0] SEQ_RST = 16'h0000;
  localparam int GRP_VOUT_EN = 21;
  localparam int GRP_VOUT_LSB = 16;
  localparam int GRP_OP_EN = 13;
  localparam int GRP_OP_LSB = 8;
  localparam int GRP_PF_IMM = 5;
  localparam int GRP_PF_LSB = 0;
  localparam logic [31:0] GRP_MASK = 32'h003f3f3f;
  localparam int CTRL_ON = 0;
  localparam int CTRL_2PH = 1;
  localparam int CTRL_ID_LSB = 8;
  localparam logic [31:0] CTRL_MASK = 32'h00001f03;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam int OP_ON_BIT = 7;
  localparam int OFF_DLY_DEF = 16;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    EV_NONE, EV_PG, EV_PDOWN, EV_VOUT, EV_OP, EV_PFAIL
  } rsg_kind_t;

  typedef struct packed {
    rsg_kind_t kind;
    logic [4:0] id;
    logic [15:0] data;
  } rsg_evt_t;

  typedef struct packed {
    logic pre_en;
    logic [4:0] pre_id;
    logic seq_en;
    logic [4:0] seq_id;
  } rsg_seq_t;

  typedef struct packed {
    logic pre_pg;
    logic seq_pd;
    logic vout;
    logic op;
    logic pf_imm;
    logic pf_seq;
  } rsg_hit_t;

  function automatic rsg_seq_t seq_of(input logic [15:0] r);
    rsg_seq_t s;
    s.pre_en = r[SEQ_PRE_EN];
    s.pre_id = r[SEQ_PRE_LSB +: ID_W];
    s.seq_en = r[SEQ_SEQ_EN];
    s.seq_id = r[SEQ_SEQ_LSB +: ID_W];
    return s;
  endfunction

endpackage

// >>> verilog/rsg_event_rx.sv
// Decodes one inter-device event bus message against the configuration.
// Assumes the message is held stable for the cycle it is qualified.
`timescale 1ns/1ps
module rsg_event_rx
  import rsg_pkg::*;
(
  input wire logic evt_valid,
  input rsg_evt_t evt,
  input rsg_seq_t seq,
  input wire logic [31:0] grp,
  input wire logic two_phase,
  output rsg_hit_t hit
);

  // ------------------------------------------------------------------
  // Match
  // ------------------------------------------------------------------
  logic pf_grp;

  always_comb
  begin
    hit = '0;
    pf_grp = evt.data[ID_W-1:0] == grp[GRP_PF_LSB +: ID_W];
    if (evt_valid)
    begin
      unique case (evt.kind)
        EV_PG: hit.pre_pg = seq.pre_en && evt.id == seq.pre_id;
        EV_PDOWN: hit.seq_pd = seq.seq_en && evt.id == seq.seq_id;
        // Group fields alone decide a broadcast match.
        EV_VOUT: hit.vout = grp[GRP_VOUT_EN] &&
          evt.data[ID_W-1:0] == grp[GRP_VOUT_LSB +: ID_W];
        EV_OP: hit.op = grp[GRP_OP_EN] &&
          evt.data[ID_W-1:0] == grp[GRP_OP_LSB +: ID_W];
        EV_PFAIL:
        begin
          // In two-phase mode any loss is immediate whatever the group holds.
          hit.pf_imm = (pf_grp && grp[GRP_PF_IMM]) || two_phase;
          hit.pf_seq = pf_grp && !grp[GRP_PF_IMM] && !two_phase;
        end
        default: hit = '0;
      endcase
    end
  end

endmodule // rsg_event_rx

// >>> sim/rsg_properties.sv
// Port checker of the rail sequence and group logic.
// Assumes a master that holds its request through the access cycle.
`timescale 1ns/1ps
module rsg_properties
  import rsg_pkg::*;
#(
  parameter int OFF_DLY = OFF_DLY_DEF
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] cfg_strap,
  input wire logic en_pin,
  input wire logic power_good_signal,
  input wire logic vout_zero,
  input wire logic supply_loss,
  input wire logic evt_rx_valid,
  input rsg_evt_t evt_rx,
  input wire logic evt_tx_valid,
  input rsg_evt_t evt_tx,
  input wire logic evt_tx_ready,
  input wire logic out_en,
  input wire logic [15:0] vout_cmd
);
  // ------------------------------------------------------------------
  // Shadow of the group register
  // ------------------------------------------------------------------
  logic [31:0] grp_r;
  logic map_hit;
  logic pf_hit;
  assign map_hit = paddr inside {ADR_SEQ, ADR_GRP, ADR_CTRL, ADR_SEND,
                                 ADR_STAT};
  assign pf_hit = evt_rx.data[4:0] == grp_r[4:0];
  // Loaded during reset, one edge early; no event uses that edge.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      grp_r <= {10'h0, cfg_strap[5], cfg_strap[4:0], 2'h0, cfg_strap[6],
                cfg_strap[4:0], 2'h0, cfg_strap[7], cfg_strap[4:0]};
    else if (ce && psel && penable && pready && pwrite && paddr == ADR_GRP)
      grp_r <= pwdata & GRP_MASK;
  end
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer one cycle after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  map_err_a: assert property (pready |-> pslverr == !map_hit)
    else $error("pslverr does not follow the map");
  unmapped_zero_a: assert property (pready && !pwrite && !map_hit
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  order_bits_a: assert property (pready && !pwrite && paddr == ADR_SEQ
    |-> (prdata & 32'hffff6060) == 32'h0) else $error("unused bits set");
  tx_hold_a: assert property (evt_tx_valid && !evt_tx_ready
    |=> evt_tx_valid && $stable(evt_tx)) else $error("event dropped");
  tx_group_a: assert property (evt_tx_valid && evt_tx.kind == EV_VOUT
    |-> evt_tx.data[4:0] == grp_r[20:16]) else $error("bad group sent");
  pf_imm_a: assert property (evt_rx_valid && evt_rx.kind == EV_PFAIL
    && grp_r[5] && pf_hit |=> !out_en) else $error("no immediate off");
  vout_ignore_a: assert property (evt_rx_valid && evt_rx.kind == EV_VOUT
    && !grp_r[21] |=> $stable(vout_cmd)) else $error("broadcast taken");
  on_needs_en_a: assert property ($rose(out_en) |-> $past(en_pin))
    else $error("output on without enable");
endmodule // rsg_properties

bind rsg_top rsg_properties #(.OFF_DLY(OFF_DLY)) u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cfg_strap(cfg_strap), .en_pin(en_pin),
  .power_good_signal(power_good_signal), .vout_zero(vout_zero),
  .supply_loss(supply_loss), .evt_rx_valid(evt_rx_valid),
  .evt_rx(evt_rx), .evt_tx_valid(evt_tx_valid), .evt_tx(evt_tx),
  .evt_tx_ready(evt_tx_ready), .out_en(out_en), .vout_cmd(vout_cmd)
);

// >>> sim/rsg_peer.sv
// Peer rail controller model on the inter-device event bus.
// Assumes the bench calls post() from its own clocked sequence.
`timescale 1ns/1ps
module rsg_peer
  import rsg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic stall,
  input wire logic evt_tx_valid,
  input rsg_evt_t evt_tx,
  output logic evt_tx_ready,
  output logic evt_rx_valid,
  output rsg_evt_t evt_rx,
  output rsg_evt_t got,
  output int acc_n
);
  initial
  begin
    evt_rx_valid = 1'b0;
    evt_rx = '0;
    got = '0;
    acc_n = 0;
  end
  // Stalling keeps ready low, so the device must hold its event up.
  assign evt_tx_ready = !stall;
  always @(posedge ref_clk)
  begin
    if (evt_tx_valid && evt_tx_ready)
    begin
      got <= evt_tx;
      acc_n <= acc_n + 1;
    end
  end
  task automatic post(input rsg_kind_t k, input logic [4:0] i,
                      input logic [15:0] d);
    @(posedge ref_clk);
    evt_rx_valid <= 1'b1;
    evt_rx <= '{kind: k, id: i, data: d};
    @(posedge ref_clk);
    evt_rx_valid <= 1'b0;
    // Idle lines change, so a stale message can never look valid.
    evt_rx <= rsg_evt_t'(~evt_rx);
  endtask
endmodule // rsg_peer

// >>> sim/tb.sv
// Self-checking bench of the rail sequence and group logic.
// Assumes the peer model and the bound checker sit beside the device.
`timescale 1ns/1ps
module tb;
  import rsg_pkg::*;
  logic ref_clk, rst_n, psel, penable, pwrite, en_pin, stall, err_v;
  logic loss, vzero;
  logic pready, pslverr, evt_rx_valid, evt_tx_valid, evt_tx_ready, out_en;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [15:0] vout_cmd;
  rsg_evt_t evt_rx, evt_tx, got;
  int acc_n, n0, fail_count, total_checks;
  rsg_kind_t kinds [3] = '{EV_VOUT, EV_OP, EV_PFAIL};
  logic [4:0] gids [3] = '{5'h15, 5'h0c, 5'h01};
  rsg_top #(.OFF_DLY(2)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_strap(8'hea), .en_pin(en_pin), .power_good_signal(1'b0),
    .vout_zero(vzero), .supply_loss(loss), .evt_rx_valid(evt_rx_valid),
    .evt_rx(evt_rx), .evt_tx_valid(evt_tx_valid), .evt_tx(evt_tx),
    .evt_tx_ready(evt_tx_ready), .out_en(out_en), .vout_cmd(vout_cmd)
  );
  rsg_peer u_peer (
    .ref_clk(ref_clk), .stall(stall), .evt_tx_valid(evt_tx_valid),
    .evt_tx(evt_tx), .evt_tx_ready(evt_tx_ready),
    .evt_rx_valid(evt_rx_valid), .evt_rx(evt_rx), .got(got), .acc_n(acc_n)
  );
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rd_v);
  endtask
  task automatic hold(input logic v, input int n);
    repeat (n) @(posedge ref_clk);
    chk("out_en", {31'h0, v}, {31'h0, out_en});
  endtask
  task automatic wait_out(input logic v);
    for (int i = 0; i < 40 && out_en !== v; i++)
      @(posedge ref_clk);
    chk("out_en", {31'h0, v}, {31'h0, out_en});
  endtask
  task automatic vchk(input logic [15:0] e);
    repeat (2) @(posedge ref_clk);
    chk("vout_cmd", {16'h0, e}, {16'h0, vout_cmd});
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial
  begin
    // The tests need about 200 cycles; this leaves a wide margin.
    repeat (8000) @(posedge ref_clk);
    fail_count++;
    summarize();
  end
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    en_pin = 1'b0;
    stall = 1'b0;
    loss = 1'b0;
    vzero = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    en_pin <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(ADR_SEQ, 32'h0);
    rd(ADR_GRP, 32'h002a2a2a);
    rd(12'h100, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err_v});
    $display("test reset done");
    apb(1'b1, ADR_CTRL, 32'h301);
    hold(1'b0, 10);
    apb(1'b1, ADR_SEQ, 32'hffff);
    rd(ADR_SEQ, 32'h9f9f);
    apb(1'b1, ADR_SEQ, 32'h0);
    wait_out(1'b1);
    apb(1'b1, ADR_CTRL, 32'h300);
    wait_out(1'b0);
    $display("test override done");
    apb(1'b1, ADR_SEQ, 32'h8587);
    rd(ADR_SEQ, 32'h8587);
    apb(1'b1, ADR_CTRL, 32'h301);
    u_peer.post(EV_PG, 5'h06, 16'h0);
    hold(1'b0, 4);
    u_peer.post(EV_PG, 5'h05, 16'h0);
    wait_out(1'b1);
    apb(1'b1, ADR_CTRL, 32'h300);
    u_peer.post(EV_PDOWN, 5'h08, 16'h0);
    hold(1'b1, 4);
    u_peer.post(EV_PDOWN, 5'h07, 16'h0);
    hold(1'b1, 1);
    wait_out(1'b0);
    $display("test sequence done");
    u_peer.post(EV_VOUT, 5'h1f, 16'h5a0a);
    vchk(16'h5a0a);
    apb(1'b1, ADR_GRP, 32'h000a2a2a);
    u_peer.post(EV_VOUT, 5'h0a, 16'h330a);
    vchk(16'h5a0a);
    u_peer.post(EV_OP, 5'h1f, 16'h008a);
    rd(ADR_CTRL, 32'h301);
    apb(1'b1, ADR_GRP, 32'h000a0a2a);
    u_peer.post(EV_OP, 5'h0a, 16'h000a);
    rd(ADR_CTRL, 32'h301);
    $display("test broadcast done");
    apb(1'b1, ADR_SEQ, 32'h0);
    wait_out(1'b1);
    u_peer.post(EV_PFAIL, 5'h0a, 16'h000b);
    hold(1'b1, 4);
    u_peer.post(EV_PFAIL, 5'h00, 16'h000a);
    hold(1'b0, 1);
    $display("test supply loss done");
    apb(1'b1, ADR_GRP, 32'h00352c21);
    for (int i = 0; i < 3; i++)
    begin
      n0 = acc_n;
      stall <= 1'b1;
      apb(1'b1, ADR_SEND, 32'h1 << i);
      repeat (4) @(posedge ref_clk);
      chk("accepted", n0, acc_n);
      stall <= 1'b0;
      for (int j = 0; j < 20 && acc_n == n0; j++)
        @(posedge ref_clk);
      chk("accepted", n0 + 1, acc_n);
      chk("kind", {29'h0, kinds[i]}, {29'h0, got.kind});
      chk("group", {27'h0, gids[i]}, {27'h0, got.data[4:0]});
      chk("rail", 32'h3, {27'h0, got.id});
    end
    // Both pin edges queue at once; the loss message goes out first.
    n0 = acc_n;
    stall <= 1'b1;
    loss <= 1'b1;
    vzero <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("kind", {29'h0, EV_PFAIL}, {29'h0, evt_tx.kind});
    chk("group", {27'h0, gids[2]}, {27'h0, evt_tx.data[4:0]});
    stall <= 1'b0;
    for (int j = 0; j < 20 && acc_n != n0 + 2; j++)
      @(posedge ref_clk);
    chk("accepted", n0 + 2, acc_n);
    chk("kind", {29'h0, EV_PDOWN}, {29'h0, got.kind});
    $display("test transmit done");
    apb(1'b1, ADR_GRP, 32'h00352c01);
    apb(1'b1, ADR_CTRL, 32'h301);
    wait_out(1'b1);
    u_peer.post(EV_PFAIL, 5'h00, 16'h0001);
    hold(1'b1, 1);
    wait_out(1'b0);
    apb(1'b1, ADR_CTRL, 32'h303);
    wait_out(1'b1);
    u_peer.post(EV_PFAIL, 5'h00, 16'h001e);
    hold(1'b0, 1);
    $display("test two-phase done");
    summarize();
  end
endmodule // tb
